// file: hdl/audio_port_pkg.sv
// Constants, types and field layout for the audio serial port and route switch
// Operation
// - Each switch output has its own selector field choosing its input.
// - Processor selector 0x1 takes port input; DAC selector 0x3 takes processor output.
// - Converter samples are a switch input, routable to any output including transmit.
// - One input may feed several outputs; processor never feeds itself.
// - Port supports I2S, left justified, right justified and PCM frame formats.
// - Software picks bit clock rate, bit clock polarity, sample length, frame polarity.
// - In stereo formats the left subframe always comes first.
// - One bit selects clock master or clock slave for both port clocks.
// - As slave, clocks must be locked to system clock; PLL mode unused.
// - As master, clocks come from system clock or the PLL tick.
// - In PCM the frame clock is only a frame start pulse.
// - In PCM right word follows left directly; remaining slots are zero.
// - In PCM data and pulse are sampled on the configured bit clock edge.
// - PCM variant A starts one bit after the pulse; variant B at once.
// - Control word 0x01F4 decodes to PCM variant A master, inverted, 16 bit.
// - As PCM slave any frame pulse width is accepted.
// - As PCM master the frame pulse is active exactly one bit clock: high, or low when frame polarity is set.
package audio_port_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ROUTE_OFS = 4'h0;
	localparam logic [3:0] FMT_OFS = 4'h4;
	localparam logic [3:0] CLK_OFS = 4'h8;
	localparam logic [3:0] STAT_OFS = 4'hc;
	localparam logic [15:0] ROUTE_RST = 16'h0000;
	localparam logic [15:0] FMT_RST = 16'h0000;
	localparam logic [15:0] CLK_RST = 16'h0000;
	localparam int RT_TX_LSB = 0;
	localparam int RT_DAC_LSB = 4;
	localparam int RT_PROC_LSB = 6;
	localparam int F_RATE = 8;
	localparam int F_MASTER = 7;
	localparam int F_INV = 6;
	localparam int F_LEN_LSB = 4;
	localparam int F_MODE_LSB = 2;
	localparam int F_ALIGN = 1;
	localparam int F_POL = 0;
	localparam int C_PLL = 0;
	localparam logic [6:0] LEN_32 = 7'h20;
	localparam logic [6:0] LEN_24 = 7'h18;
	localparam logic [6:0] LEN_20 = 7'h14;
	localparam logic [6:0] LEN_16 = 7'h10;
	localparam logic [6:0] LAST_64 = 7'h3f;
	localparam logic [6:0] LAST_32 = 7'h1f;
	localparam logic [6:0] HALF_64 = 7'h20;
	localparam logic [6:0] HALF_32 = 7'h10;
	localparam int CLK_NS = 8;
	localparam int BCLK_HALF_NS = 64;
	localparam int BCLK_HALF_CYC = BCLK_HALF_NS / CLK_NS;
	typedef enum logic [1:0] {
		SRC_ADC = 2'b00,
		SRC_PORT = 2'b01,
		SRC_NONE = 2'b10,
		SRC_PROC = 2'b11
	} src_t;
	typedef enum logic [1:0] {
		FMT_I2S = 2'b00,
		FMT_PCM = 2'b01,
		FMT_RJ = 2'b10,
		FMT_RSV = 2'b11
	} mode_t;
	typedef struct packed {
		logic [31:0] left;
		logic [31:0] right;
	} sample_t;
endpackage

// file: hdl/audio_port_and_route_switch.sv
// Audio serial port with frame formats, clocking and the source route switch
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module audio_port_and_route_switch import audio_port_pkg::*; #(
	parameter int HALF_CYC = BCLK_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic pll_tick,
	input wire logic bclk_in,
	output logic bclk_out,
	output logic bclk_oe,
	input wire logic lrclk_in,
	output logic lrclk_out,
	output logic lrclk_oe,
	input wire logic sdata_in,
	output logic sdata_out,
	input wire logic adc_valid,
	output logic adc_ready,
	input wire sample_t adc_data,
	input wire logic proc_out_valid,
	output logic proc_out_ready,
	input wire sample_t proc_out_data,
	output logic proc_in_valid,
	input wire logic proc_in_ready,
	output sample_t proc_in_data,
	output logic dac_valid,
	input wire logic dac_ready,
	output sample_t dac_data
);
	logic [15:0] route_reg, fmt_reg, clk_reg, rdata_reg;
	logic [2:0] bclk_sync;
	logic [1:0] lr_sync, sd_sync;
	logic [15:0] div_cnt;
	logic phase_reg, lr_prev, lr_out_reg, sd_out_reg;
	logic [6:0] slot_reg;
	logic [31:0] rx_sh, rx_left, tx_l, tx_r;
	sample_t rx_sample, buf_mem [2];
	logic rx_valid, wp, rp;
	logic [1:0] cnt;

	// Register port
	wire wr_route = reg_wr && (reg_addr == ROUTE_OFS);
	wire wr_fmt = reg_wr && (reg_addr == FMT_OFS);
	wire wr_clk = reg_wr && (reg_addr == CLK_OFS);
	wire [15:0] stat_word = {12'h000, lr_prev, cnt, fmt_reg[F_MASTER]};
	wire [15:0] rd_mux = (reg_addr == ROUTE_OFS) ? route_reg :
		(reg_addr == FMT_OFS) ? fmt_reg :
		(reg_addr == CLK_OFS) ? clk_reg :
		(reg_addr == STAT_OFS) ? stat_word : 16'h0000;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			route_reg <= ROUTE_RST;
			fmt_reg <= FMT_RST;
			clk_reg <= CLK_RST;
			rdata_reg <= 16'h0000;
		end else begin
			if (wr_route)
				route_reg <= reg_wdata;
			if (wr_fmt)
				fmt_reg <= reg_wdata;
			if (wr_clk)
				clk_reg <= reg_wdata;
			rdata_reg <= reg_rd ? rd_mux : 16'h0000;
		end
	end
	assign reg_rdata = rdata_reg;

	// Format decode
	wire master = fmt_reg[F_MASTER];
	wire inv = fmt_reg[F_INV];
	wire pol = fmt_reg[F_POL];
	wire [1:0] len_code = fmt_reg[F_LEN_LSB +: 2];
	wire mode_t mode = mode_t'(fmt_reg[F_MODE_LSB +: 2]);
	wire pcm = (mode == FMT_PCM);
	wire rj = (mode == FMT_RJ);
	wire [6:0] len = (len_code == 2'd0) ? LEN_32 : (len_code == 2'd1) ? LEN_24 :
		(len_code == 2'd2) ? LEN_20 : LEN_16;
	wire [6:0] last = fmt_reg[F_RATE] ? LAST_32 : LAST_64;
	wire [6:0] half = fmt_reg[F_RATE] ? HALF_32 : HALF_64;
	// Variant A and I2S delay one bit; variant B and left justified do not
	wire [6:0] dly = {6'h00, !rj && !fmt_reg[F_ALIGN]};
	wire [6:0] l_start = rj ? 7'(half - len) : dly;
	wire [6:0] r_start = pcm ? 7'(dly + len) :
		rj ? 7'(last + 7'h01 - len) : 7'(half + dly);
	wire [6:0] r_end = 7'(r_start + len);

	// Link pins; first stage feeds only the second
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bclk_sync <= 3'h0;
			lr_sync <= 2'h0;
			sd_sync <= 2'h0;
		end else begin
			bclk_sync <= {bclk_sync[1:0], bclk_in};
			lr_sync <= {lr_sync[0], lrclk_in};
			sd_sync <= {sd_sync[0], sdata_in};
		end
	end
	wire s_rise = bclk_sync[1] && !bclk_sync[2];
	wire s_fall = !bclk_sync[1] && bclk_sync[2];

	// Master bit clock; PLL tick replaces the divider in asynchronous mode
	wire div_tick = (div_cnt == 16'(HALF_CYC - 1));
	wire tick = master && (clk_reg[C_PLL] ? pll_tick : div_tick);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 16'h0000;
			phase_reg <= 1'b0;
		end else begin
			div_cnt <= (div_tick || !master) ? 16'h0000 : 16'(div_cnt + 16'h0001);
			if (tick)
				phase_reg <= !phase_reg;
		end
	end
	wire raw_rise = master ? (tick && !phase_reg) : s_rise;
	wire raw_fall = master ? (tick && phase_reg) : s_fall;
	wire launch = inv ? raw_rise : raw_fall;
	wire capture = inv ? raw_fall : raw_rise;

	// Slot counter; a slave realigns it on each detected frame start
	wire [6:0] slot_next = (slot_reg == last) ? 7'h00 : 7'(slot_reg + 7'h01);
	wire lr_lvl = lr_sync[1] ^ pol;
	// Only the leading edge of a PCM pulse counts, so its width is free
	wire fstart = pcm ? (lr_lvl && !lr_prev) : (!lr_lvl && lr_prev);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			slot_reg <= 7'h00;
			lr_prev <= 1'b0;
		end else begin
			if (launch)
				slot_reg <= slot_next;
			else if (capture && !master && fstart)
				slot_reg <= 7'h00;
			if (capture)
				lr_prev <= lr_lvl;
		end
	end

	// Transmit bit for the coming slot
	wire n_left = (slot_next >= l_start) && (slot_next < 7'(l_start + len));
	wire n_right = (slot_next >= r_start) && (slot_next < r_end);
	wire [6:0] n_idx = n_left ? 7'(len - 7'h01 - (slot_next - l_start)) :
		7'(len - 7'h01 - (slot_next - r_start));
	wire tx_bit = n_left ? tx_l[n_idx[4:0]] : n_right ? tx_r[n_idx[4:0]] : 1'b0;
	wire lr_next = (pcm ? (slot_next == 7'h00) : (slot_next >= half)) ^ pol;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lr_out_reg <= 1'b0;
			sd_out_reg <= 1'b0;
		end else if (launch) begin
			lr_out_reg <= lr_next;
			sd_out_reg <= tx_bit;
		end
	end
	assign bclk_out = phase_reg;
	assign lrclk_out = lr_out_reg;
	assign bclk_oe = master;
	assign lrclk_oe = master;
	assign sdata_out = sd_out_reg;

	// Receive, MSB first, right aligned at the programmed length
	// Slots ahead of the left window count as past the last slot, where a right word running past the frame end has its tail
	wire [6:0] c_slot = (slot_reg < l_start) ? 7'(slot_reg + last + 7'h01) : slot_reg;
	wire c_left = (c_slot >= l_start) && (c_slot < 7'(l_start + len));
	wire c_right = (c_slot >= r_start) && (c_slot < r_end);
	wire [31:0] sh_next = {rx_sh[30:0], sd_sync[1]};
	wire [31:0] len_mask = ~(32'hffffffff << len);
	wire l_done = capture && c_left && (c_slot == 7'(l_start + len - 7'h01));
	wire r_done = capture && c_right && (c_slot == 7'(r_end - 7'h01));
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_sh <= 32'h00000000;
			rx_left <= 32'h00000000;
			rx_sample <= '0;
			rx_valid <= 1'b0;
		end else begin
			if (capture && (c_left || c_right))
				rx_sh <= sh_next;
			if (l_done)
				rx_left <= sh_next & len_mask;
			if (r_done)
				rx_sample <= '{left: rx_left, right: sh_next & len_mask};
			rx_valid <= r_done;
		end
	end

	// Route switch: a source advances only when every output on it accepts
	wire [1:0] sel [3];
	assign sel[0] = route_reg[RT_TX_LSB +: 2];
	assign sel[1] = route_reg[RT_DAC_LSB +: 2];
	assign sel[2] = route_reg[RT_PROC_LSB +: 2];
	wire proc_loop = (src_t'(sel[2]) == SRC_PROC);
	wire [2:0] sel_ok = {!proc_loop, 2'b11};
	wire buf_ready = (cnt != 2'd2);
	wire [2:0] out_rdy = {proc_in_ready, dac_ready, buf_ready};
	wire [3:0] src_v = {proc_out_valid, 1'b0, rx_valid, adc_valid};
	sample_t src_d [4];
	assign src_d[0] = adc_data;
	assign src_d[1] = rx_sample;
	assign src_d[2] = '0;
	assign src_d[3] = proc_out_data;
	wire [2:0] hit [4];
	wire [3:0] src_rdy;
	wire [2:0] out_v;
	sample_t out_d [3];
	genvar j, k;
	generate
		for (j = 0; j < 4; j++) begin : g_src
			for (k = 0; k < 3; k++) begin : g_hit
				assign hit[j][k] = sel_ok[k] && (sel[k] == 2'(j));
			end
			assign src_rdy[j] = &(~hit[j] | out_rdy);
		end
		for (k = 0; k < 3; k++) begin : g_out
			assign out_v[k] = sel_ok[k] && src_v[sel[k]] && src_rdy[sel[k]];
			assign out_d[k] = sel_ok[k] ? src_d[sel[k]] : '0;
		end
	endgenerate
	assign adc_ready = src_rdy[0];
	assign proc_out_ready = src_rdy[3];
	assign dac_valid = out_v[1];
	assign dac_data = out_d[1];
	assign proc_in_valid = out_v[2];
	assign proc_in_data = out_d[2];

	// Two-entry transmit buffer; refilled in the last slot, silence on underrun
	wire push = out_v[0];
	wire pop_slot = capture && (slot_reg == last);
	wire pop = pop_slot && (cnt != 2'd0);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'd0;
			tx_l <= 32'h00000000;
			tx_r <= 32'h00000000;
		end else begin
			if (push) begin
				buf_mem[wp] <= out_d[0];
				wp <= !wp;
			end
			if (pop)
				rp <= !rp;
			cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
			if (pop_slot) begin
				tx_l <= pop ? buf_mem[rp].left : 32'h00000000;
				tx_r <= pop ? buf_mem[rp].right : 32'h00000000;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	proc_no_loop_a: assert property (proc_loop |-> !proc_in_valid && proc_in_data == '0)
		else $error("processor fed from its own output");
	dac_route_a: assert property ((src_t'(sel[1]) == SRC_PROC && dac_valid)
		|-> dac_data == proc_out_data && proc_out_ready)
		else $error("dac not fed from processor");
	proc_route_a: assert property ((src_t'(sel[2]) == SRC_PORT && rx_valid
		&& proc_in_ready && dac_ready && buf_ready) |-> proc_in_valid && proc_in_data == rx_sample)
		else $error("processor not fed from port");
	pcm_pulse_a: assert property ((launch && master && pcm)
		|=> (lrclk_out ^ pol) == (slot_reg == 7'h00))
		else $error("frame pulse not one bit wide");
	pcm_pad_a: assert property ((launch && pcm && slot_next >= r_end) |=> !sdata_out)
		else $error("pad slot not zero");
	left_first_a: assert property ((launch && !pcm && slot_next == l_start)
		|=> sdata_out == tx_l[5'(len - 7'h01)])
		else $error("left msb not first");
	slave_clock_a: assert property (!master |-> !bclk_oe && !lrclk_oe && !tick)
		else $error("slave drives clocks");
	rx_word_a: assert property (r_done |=> rx_valid ##1 !rx_valid)
		else $error("receive word not delivered");
	buf_full_a: assert property ((cnt == 2'd2) |-> !push)
		else $error("buffer overrun");
	oe_master_a: assert property ((bclk_oe == master) && (lrclk_oe == master))
		else $error("clock enables do not follow master bit");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
	rdata_fmt_a: assert property ((reg_rd && reg_addr == FMT_OFS)
		|=> reg_rdata == $past(fmt_reg))
		else $error("format read data wrong");
	fmt_write_a: assert property (wr_fmt |=> fmt_reg == $past(reg_wdata))
		else $error("format write lost");
	route_write_a: assert property (wr_route |=> route_reg == $past(reg_wdata))
		else $error("route write lost");
	dac_select_a: assert property ((src_t'(sel[1]) != SRC_NONE)
		|-> dac_data == src_d[sel[1]])
		else $error("dac data not from its selector");
	proc_select_a: assert property ((!proc_loop && src_t'(sel[2]) != SRC_NONE)
		|-> proc_in_data == src_d[sel[2]])
		else $error("processor data not from its selector");
	none_source_a: assert property ((src_t'(sel[1]) == SRC_NONE) |-> !dac_valid)
		else $error("empty input produced a sample");
	adc_fanout_a: assert property ((adc_valid && adc_ready
		&& src_t'(sel[1]) == SRC_ADC) |-> dac_valid)
		else $error("converter sample not sent to dac");
	adc_to_tx_a: assert property ((adc_valid && adc_ready
		&& src_t'(sel[0]) == SRC_ADC) |-> push)
		else $error("converter sample not sent to transmit");
	buf_count_a: assert property (cnt != 2'd3)
		else $error("buffer count out of range");
	lr_stereo_a: assert property ((launch && master && !pcm)
		|=> (lrclk_out ^ pol) == (slot_reg >= half))
		else $error("frame level wrong for channel");
	div_spacing_a: assert property ((master && !clk_reg[C_PLL] && tick) |=> !tick)
		else $error("divider ticks too close");
	pll_edge_a: assert property ((master && clk_reg[C_PLL] && pll_tick) |-> tick)
		else $error("pll tick ignored");
	edge_split_a: assert property (!(launch && capture))
		else $error("launch and capture on one edge");
	slave_align_a: assert property ((capture && !master && fstart)
		|=> slot_reg == 7'h00)
		else $error("slave did not realign on frame start");
	rx_shift_a: assert property ((capture && (c_left || c_right))
		|=> rx_sh[0] == $past(sd_sync[1]))
		else $error("receive bit not shifted in");
	rx_left_a: assert property (l_done |=> rx_left == $past(sh_next & len_mask))
		else $error("left word not kept");
	underrun_zero_a: assert property ((pop_slot && cnt == 2'd0)
		|=> tx_l == 32'h00000000 && tx_r == 32'h00000000)
		else $error("underrun frame not silent");
	out_hold_a: assert property (!launch |=> $stable(lrclk_out) && $stable(sdata_out))
		else $error("link outputs moved between launches");

	pcm_frame_c: cover property (launch && master && pcm && slot_next == 7'h00);
	slave_start_c: cover property (capture && !master && fstart && slot_reg != 7'h00);
	buf_full_c: cover property (cnt == 2'd2);
	fanout_c: cover property (dac_valid && proc_in_valid && sel[1] == sel[2]);
	slave_word_c: cover property (r_done && !master);
endmodule

// file: dv/far_side_model.sv
// Far side model: clock-master processor that sends stereo I2S frames
`timescale 1ns/1ps
module far_side_model (
	output logic bclk,
	output logic lrclk,
	output logic sdata
);
	initial begin
		bclk = 1'b1;
		lrclk = 1'b1;
		sdata = 1'b0;
	end
	// Bit clock stands still high between calls, so no stray edges reach the port
	task automatic send(input logic [15:0] l, input logic [15:0] r, input int n);
		logic b;
		for (int f = 0; f <= n; f++) begin
			for (int s = 0; s < 32; s++) begin
				if (f == n && s > 0) break;
				b = (s == 0) ? (f > 0 && r[0]) : (s <= 16 ? l[16 - s] : r[32 - s]);
				bclk = 1'b0;
				lrclk = (s >= 16);
				sdata = b;
				#62.5 bclk = 1'b1;
				#62.5;
			end
		end
		// Released data line must not keep showing the last bit
		sdata = ~sdata;
	endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the audio port and route switch
`timescale 1ns/1ps
module testbench;
	import audio_port_pkg::*;
	localparam int HALF = 8;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic [DATA_W-1:0] reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pll_tick = 1'b0;
	logic bclk_out, bclk_oe, lrclk_out, lrclk_oe, sdata_out, bclk_in, lrclk_in, sdata_in;
	logic adc_valid = 1'b0, adc_ready, proc_out_valid = 1'b0, proc_out_ready;
	logic proc_in_valid, proc_in_ready = 1'b0, dac_valid, dac_ready = 1'b0;
	sample_t adc_data = '0, proc_out_data = '0, proc_in_data, dac_data, last;
	int fail_count = 0, compares = 0, w, n;
	logic [31:0] seed = 32'h38f82e71, r, bits;
	logic [15:0] rd_val;
	logic pb, busy;
	// Master divider gives 512 system clocks per 32-slot frame
	always #4 ref_clk = ~ref_clk;
	audio_port_and_route_switch #(.HALF_CYC(HALF)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pll_tick(pll_tick), .bclk_in(bclk_in), .bclk_out(bclk_out),
		.bclk_oe(bclk_oe), .lrclk_in(lrclk_in), .lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe),
		.sdata_in(sdata_in), .sdata_out(sdata_out), .adc_valid(adc_valid), .adc_ready(adc_ready),
		.adc_data(adc_data), .proc_out_valid(proc_out_valid), .proc_out_ready(proc_out_ready),
		.proc_out_data(proc_out_data), .proc_in_valid(proc_in_valid),
		.proc_in_ready(proc_in_ready), .proc_in_data(proc_in_data), .dac_valid(dac_valid),
		.dac_ready(dac_ready), .dac_data(dac_data));
	far_side_model i_far (.bclk(bclk_in), .lrclk(lrclk_in), .sdata(sdata_in));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic vsel(int s);
		return s == 0 ? adc_valid : (s == 3 ? proc_out_valid : 1'b0);
	endfunction
	// A source moves only when every output routed to it is ready
	function logic srdy(int s, int d, int p);
		return (d != s || dac_ready) && (p == 3 || p != s || proc_in_ready);
	endfunction
	// Slot s holds left word from delay d, right word right after it, zeros elsewhere
	function logic [31:0] pcm_exp(int d, logic [15:0] l, logic [15:0] rr);
		logic [31:0] e;
		e = '0;
		for (int s = 0; s < 32; s++) begin
			if (s >= d && s < d + 16) e[31 - s] = l[15 - (s - d)];
			else if (s >= d + 16 && s < d + 32) e[31 - s] = rr[15 - (s - d - 16)];
		end
		return e;
	endfunction
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task summarize;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task tick;
		@(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task wait_rise;
		pb = lrclk_out;
		tick;
		for (int i = 0; i < 4000 && !(pb === 1'b0 && lrclk_out === 1'b1); i++) begin
			pb = lrclk_out;
			tick;
		end
	endtask
	initial begin
		repeat (30000) @(posedge ref_clk);
		fail_count++;
		$display("timeout waiting for the design");
		summarize;
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(ROUTE_OFS);
		check("route reset", rd_val, ROUTE_RST);
		rd(FMT_OFS);
		check("format reset", rd_val, FMT_RST);
		rd(4'h2);
		check("unmapped read", rd_val, 0);
		wr(FMT_OFS, 16'h01f4);
		rd(FMT_OFS);
		check("format word", rd_val, 16'h01f4);
		rd(STAT_OFS);
		check("master status", rd_val[0], 1);
		check("clock enables", {bclk_oe, lrclk_oe}, 2'b11);
		wr(FMT_OFS, 16'h0000);
		$display("test registers done");
		// Every selector pair, with random data and random readiness on both sides
		for (int d = 0; d < 4; d++) for (int p = 0; p < 4; p++) begin
			wr(ROUTE_OFS, 16'(p * 64 + d * 16 + 2));
			r = rnd();
			@(posedge ref_clk);
			adc_data <= {rnd(), rnd()};
			proc_out_data <= {rnd(), rnd()};
			adc_valid <= 1'b1;
			proc_out_valid <= r[0];
			dac_ready <= r[1];
			proc_in_ready <= r[2];
			tick;
			check("dac valid", dac_valid, vsel(d) && srdy(d, d, p));
			if (d == 0) check("dac data", dac_data, adc_data);
			if (d == 3) check("dac data", dac_data, proc_out_data);
			check("proc valid", proc_in_valid, p == 3 ? 1'b0 : vsel(p) && srdy(p, d, p));
			if (p == 0) check("proc data", proc_in_data, adc_data);
			if (p == 3) check("proc blocked data", proc_in_data, 64'h0);
			check("proc ready", proc_out_ready, srdy(3, d, p));
			check("adc ready", adc_ready, (d != 0 || dac_ready) && (p != 0 || proc_in_ready));
		end
		$display("test route switch done");
		for (int a = 0; a < 2; a++) begin
			r = rnd();
			adc_data <= {16'h0, r[31:16], 16'h0, r[15:0]};
			wr(ROUTE_OFS, 16'h00a0);
			wr(FMT_OFS, 16'(16'h01f4 + a * 2));
			repeat (4) wait_rise;
			check("master enables", {bclk_oe, lrclk_oe}, 2'b11);
			w = 0;
			while (lrclk_out === 1'b1 && w < 100) begin
				tick;
				w++;
			end
			check("frame pulse width", w, 2 * HALF);
			wait_rise;
			n = 0;
			pb = bclk_out;
			for (int i = 0; i < 1200 && n < 32; i++) begin
				tick;
				if (pb === 1'b1 && bclk_out === 1'b0) begin
					bits[31 - n] = sdata_out;
					n++;
				end
				pb = bclk_out;
			end
			check("pcm frame", bits, pcm_exp(1 - a, r[31:16], r[15:0]));
		end
		$display("test pcm master done");
		adc_valid <= 1'b0;
		dac_ready <= 1'b1;
		wr(FMT_OFS, 16'h0130);
		wr(ROUTE_OFS, 16'h0092);
		tick;
		check("slave enables", {bclk_oe, lrclk_oe}, 2'b00);
		r = rnd();
		busy = 1'b1;
		last = '0;
		fork
			begin
				i_far.send(r[31:16], r[15:0], 4);
				repeat (40) tick;
				busy = 1'b0;
			end
			while (busy) begin
				tick;
				if (dac_valid === 1'b1) last = dac_data;
			end
		join
		check("rx left", last.left[15:0], r[31:16]);
		check("rx right", last.right[15:0], r[15:0]);
		$display("test i2s slave done");
		summarize;
	end
endmodule
